/* rtl/dpsc_power_ctl.v */
// dpsc_power_ctl.v - cke driven power-state control of a ddr2 device
// Function
// - action from cke pair and command
// - fall picks precharge or active power-down
// - refresh with cke fall enters self refresh
// - no refresh while in power-down
// - odt ignored by states, off in self refresh
// - unlisted combinations flagged illegal
// - write auto precharge then entry accepted
// - precharge power-down one clock after ref/pre
// - active power-down one clock after activate
// - mr bit 12 selects exit speed
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.vh"
module dpsc_power_ctl #(
  parameter XSRD_CLK = `DPSC_XSRD_CLK
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // pins from the controller
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [2:0]  ba,
  input  wire        a10,
  input  wire        odt,
  // mode register field
  input  wire        mr_slow_exit,
  // device busy with a burst or mode load
  input  wire        op_busy,
  // state outputs
  output reg         st_active,
  output reg         st_ppd,
  output reg         st_apd,
  output reg         st_sref,
  output reg         slow_exit,
  output reg         refresh_en,
  output reg         odt_en,
  output reg         read_ok,
  output reg         illegal
);
  ////////////////////////////////////////////////////////////////////
  // state codes, one-hot
  localparam [3:0] S_ACT  = 4'h1;  // clock enabled
  localparam [3:0] S_PPD  = 4'h2;  // precharge power-down
  localparam [3:0] S_APD  = 4'h4;  // active power-down
  localparam [3:0] S_SREF = 4'h8;  // self refresh

  reg  [3:0] state_reg;    // power state
  reg  [3:0] state_next;   // next power state
  // cke_reg resets high, matching the idle pin, so reset never fakes a fall
  reg        cke_reg;      // cke at previous edge
  reg  [7:0] xsrd_reg;     // clocks since self refresh exit
  reg  [7:0] xsrd_next;    // next count
  reg        ill_next;     // illegal combination seen
  wire [3:0] cmd;          // decoded command bus
  wire       is_nop;       // nop or deselect
  wire       any_open;     // a row is open now
  wire       idle_after;   // all idle after this command

  // deselect counts as nop
  function nop_or_desel;
    input       f_cs_n;
    input [3:0] f_cmd;
    begin
      nop_or_desel = f_cs_n | (f_cmd == `DPSC_CMD_NOP);
    end
  endfunction

  assign cmd    = {cs_n, ras_n, cas_n, we_n};
  assign is_nop = nop_or_desel(cs_n, cmd);

  ////////////////////////////////////////////////////////////////////
  // bank tracking; entries one clock after act/pre/ref are legal
  // commands only count while cke was high at the previous edge
  dpsc_bank_track #(
    .NBANK (8)
  ) u_bank (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .cmd_valid      (cke_reg & ~cs_n),
    .cmd            (cmd),
    .bank           (ba),
    .a10            (a10),
    .any_open       (any_open),
    .all_idle_after (idle_after)
  );

  ////////////////////////////////////////////////////////////////////
  // next-state from cke pair and command; odt not consulted
  always @* begin
    state_next = state_reg;
    ill_next   = 1'b0;
    // low-to-low pairs hold power-down and self refresh; every command
    // is don't-care there, so only the rising edge is decoded
    case (state_reg)
      S_ACT: begin
        if (cke_reg && !cke) begin
          // a nop fall while busy is refused and flagged like any other
          // unlisted pair; the device then stays with the clock enabled
          if (is_nop && !op_busy) begin
            // idle banks pick precharge power-down
            if (!any_open) state_next = S_PPD;
            else state_next = S_APD;
          end else if (!cs_n && cmd == `DPSC_CMD_REF
                       && idle_after) begin
            // every bank idle after this edge, so no open row is lost
            state_next = S_SREF;
          end else begin
            ill_next = 1'b1;
          end
        end
      end
      S_PPD, S_APD: begin
        if (cke) begin
          if (is_nop) state_next = S_ACT;
          else ill_next = 1'b1;
        end
      end
      S_SREF: begin
        if (cke) begin
          if (is_nop) state_next = S_ACT;
          else ill_next = 1'b1;
        end
      end
      default: state_next = S_ACT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // read window after self refresh exit; the count saturates at the
  // limit so it never wraps and closes the window again by itself
  always @* begin
    xsrd_next = xsrd_reg;
    if (state_reg == S_SREF && state_next == S_ACT)
      xsrd_next = 8'h00;
    else if (xsrd_reg < XSRD_CLK[7:0])
      xsrd_next = xsrd_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_ACT;
      cke_reg   <= `DPSC_CKE_RST;
      // start at the limit: reads are open straight after reset
      xsrd_reg  <= XSRD_CLK[7:0];
      illegal   <= 1'b0;
      slow_exit <= 1'b0;
    end else begin
      state_reg <= state_next;
      cke_reg   <= cke;
      xsrd_reg  <= xsrd_next;
      illegal   <= ill_next;
      // exit speed is fixed at active power-down entry; a later mode change waits
      if (state_next == S_APD && state_reg == S_ACT)
        slow_exit <= mr_slow_exit;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state outputs from registers; they load from state_next so they
  // always agree with state_reg, changing at the deciding edge itself
  // refresh runs in active (by command) and in self refresh (inside)
  always @(posedge ref_clk) begin
    if (rst) begin
      st_active  <= 1'b1;
      st_ppd     <= 1'b0;
      st_apd     <= 1'b0;
      st_sref    <= 1'b0;
      refresh_en <= 1'b1;
      odt_en     <= 1'b0;
      read_ok    <= 1'b1;
    end else begin
      st_active  <= state_next[0];
      st_ppd     <= state_next[1];
      st_apd     <= state_next[2];
      st_sref    <= state_next[3];
      refresh_en <= state_next[0] | state_next[3];
      odt_en     <= odt & ~state_next[3];
      read_ok    <= state_next[0] &
                    (xsrd_next >= XSRD_CLK[7:0]);
    end
  end
endmodule // dpsc_power_ctl
`default_nettype wire

/* inc/dpsc_map.vh */
// dpsc_map.vh - constants for the cke power-state block
`ifndef DPSC_MAP_VH
`define DPSC_MAP_VH
// command encodings {cs_n, ras_n, cas_n, we_n}
`define DPSC_CMD_NOP      4'h7
`define DPSC_CMD_ACT      4'h3
`define DPSC_CMD_READ     4'h5
`define DPSC_CMD_WRITE    4'h4
`define DPSC_CMD_PRE      4'h2
`define DPSC_CMD_REF      4'h1
`define DPSC_CMD_LM       4'h0
// mode register field positions
`define DPSC_MR_PDX_BIT   12
// timing counts in clocks
`define DPSC_XSRD_CLK     200
`define DPSC_CKE_MIN_CLK  3
`define DPSC_FCHG_CLK     2
// reset values
`define DPSC_CKE_RST      1'b1
`endif

/* rtl/dpsc_bank_track.v */
// dpsc_bank_track.v - open-row tracker across eight banks
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.vh"
module dpsc_bank_track #(
  parameter NBANK = 8
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // command straight from the pins, qualified by cmd_valid
  input  wire             cmd_valid,
  input  wire [3:0]       cmd,
  input  wire [2:0]       bank,
  input  wire             a10,
  // bank status
  output wire             any_open,
  output wire             all_idle_after
);
  reg  [NBANK-1:0] open_reg;   // one bit per bank
  reg  [NBANK-1:0] open_next;  // next open map

  // row open/close bookkeeping
  always @* begin
    open_next = open_reg;
    if (cmd_valid) begin
      if (cmd == `DPSC_CMD_ACT) begin
        open_next[bank] = 1'b1;
      end else if (cmd == `DPSC_CMD_PRE) begin
        if (a10) open_next = {NBANK{1'b0}};
        else open_next[bank] = 1'b0;
      end
    end
  end

  // state register
  always @(posedge ref_clk) begin
    if (rst) open_reg <= {NBANK{1'b0}};
    else open_reg <= open_next;
  end

  assign any_open       = |open_reg;
  assign all_idle_after = ~|open_next;
endmodule // dpsc_bank_track
`default_nettype wire

/* tb/dpsc_ctl_model.sv */
// controller-side model driving cke and the command pins
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.vh"
module dpsc_ctl_model (
  // clock
  input  wire logic       ref_clk,
  // pins toward the device
  output var  logic       cke,
  output var  logic [3:0] cmd,
  output var  logic [2:0] ba,
  output var  logic       a10
);
  initial {cke, cmd, ba, a10} = {1'b1, `DPSC_CMD_NOP, 4'h0};
  // clock rate never changes and low spans stay short, so no relock,
  // dll reset or refresh catch-up is owed
  // one command, then nop while cke holds for n edges
  task automatic drv(input logic k, input logic [3:0] c, b, input int n);
    @(posedge ref_clk);
    {cke, cmd, ba, a10} <= {k, c, b};
    repeat (n - 1) begin
      @(posedge ref_clk);
      cmd <= `DPSC_CMD_NOP;
    end
  endtask
endmodule // dpsc_ctl_model
`default_nettype wire

/* tb/dpsc_power_ctl_properties.sv */
// port-level assertions for the power-state block
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.vh"
module dpsc_power_ctl_properties #(parameter XSRD_CLK = 200) (
  input wire logic ref_clk, rst, cke, cs_n, ras_n, cas_n, we_n,
  input wire logic op_busy, st_active, st_ppd, st_apd, st_sref,
  input wire logic refresh_en, odt_en, read_ok, illegal
);
  logic       cke_d;    // cke at the previous edge
  logic [7:0] xit_cnt;  // edges since self refresh was last seen
  wire nop = cs_n | (ras_n & cas_n & we_n);
  wire fall = st_active & cke_d & !cke & !op_busy;
  always @(posedge ref_clk) cke_d <= cke;
  always @(posedge ref_clk) begin
    if (rst) xit_cnt <= 8'hff;
    else if (st_sref) xit_cnt <= 8'h00;
    else if (xit_cnt != 8'hff) xit_cnt <= xit_cnt + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pd_entry: assert property (fall && nop |=> st_ppd || st_apd)
    else $error("no power-down entry");
  a_sref_entry: assert property (fall && {cs_n, ras_n, cas_n, we_n}
    == `DPSC_CMD_REF |=> st_sref || illegal) else $error("no sref");
  a_low_hold: assert property (!st_active && !cke
    |=> $stable({st_ppd, st_apd, st_sref})) else $error("left low");
  a_pd_exit: assert property (!st_active && cke && nop |=> st_active)
    else $error("no exit");
  a_exit_refuse: assert property (!st_active && cke && !nop
    |=> !st_active && illegal) else $error("bad exit taken");
  a_pd_norefresh: assert property (st_ppd || st_apd |-> !refresh_en)
    else $error("refresh in power-down");
  a_sref_odt_off: assert property (st_sref |-> !odt_en)
    else $error("odt in sref");
  a_read_hold: assert property (xit_cnt < XSRD_CLK |-> !read_ok)
    else $error("read open too early");
  a_read_open: assert property (st_active && xit_cnt >= XSRD_CLK
    |-> read_ok) else $error("read still closed");
  cover property (st_apd);
  cover property (st_ppd);
  cover property (st_sref ##1 st_active);
endmodule // dpsc_power_ctl_properties
bind dpsc_power_ctl dpsc_power_ctl_properties #(.XSRD_CLK(XSRD_CLK))
  dpsc_power_ctl_properties_inst (.ref_clk(ref_clk), .rst(rst),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .op_busy(op_busy), .st_active(st_active), .st_ppd(st_ppd),
  .st_apd(st_apd), .st_sref(st_sref), .refresh_en(refresh_en),
  .odt_en(odt_en), .read_ok(read_ok), .illegal(illegal));
`default_nettype wire

/* tb/dpsc_power_ctl_test.sv */
// self-checking bench for the power-state block
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.vh"
module dpsc_power_ctl_test;
  logic ref_clk = 0, rst = 1, odt = 0, mr_slow_exit = 0, op_busy = 0;
  logic cke, a10, ill_seen = 0;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic [17:0] q[$], e;
  logic [31:0] r = 32'h94f9;
  int errors = 0, check_count = 0, cyc = 0;
  wire st_active, st_ppd, st_apd, st_sref, slow_exit;
  wire refresh_en, odt_en, read_ok, illegal;
  wire [8:0] obs = {st_active, st_ppd, st_apd, st_sref, slow_exit,
                    refresh_en, odt_en, read_ok, ill_seen};
  initial forever #12.5 ref_clk = ~ref_clk;
  dpsc_ctl_model m (.ref_clk(ref_clk), .cke(cke), .cmd(cmd), .ba(ba),
    .a10(a10));
  dpsc_power_ctl #(.XSRD_CLK(10)) dpsc_power_ctl_inst (.ref_clk(ref_clk),
    .rst(rst), .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
    .we_n(cmd[0]), .ba(ba), .a10(a10), .odt(odt), .op_busy(op_busy),
    .mr_slow_exit(mr_slow_exit), .st_active(st_active), .st_ppd(st_ppd),
    .st_apd(st_apd), .st_sref(st_sref), .slow_exit(slow_exit),
    .refresh_en(refresh_en), .odt_en(odt_en), .read_ok(read_ok),
    .illegal(illegal));
  task ex(input logic [8:0] k, v);
    q.push_back({k, v});
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // sticky illegal flag and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (illegal === 1'b1) ill_seen <= 1'b1;
    if (cyc == 2000) begin
      errors++;
      report_and_stop;
    end
  end
  // oldest note against settled outputs
  always @(negedge ref_clk) if (q.size() > 0) begin
    e = q.pop_front();
    check_count++;
    if (((obs ^ e[8:0]) & e[17:9]) !== 9'h0) begin
      errors++;
      $display("MISMATCH t=%0t obs=%b exp=%b", $time, obs, e[8:0]);
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    m.drv(0, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e9, 9'h080);
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e8, 9'h108);
    r = lfsr(r);
    mr_slow_exit <= r[0];
    odt <= r[1];
    m.drv(1, `DPSC_CMD_ACT, 4'h4, 1);
    m.drv(0, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1fc, {4'h2, r[0], 1'b0, r[1], 2'h0});
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    m.drv(1, `DPSC_CMD_PRE, 4'h1, 1);
    m.drv(0, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e8, 9'h080);
    odt <= 1;
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    m.drv(0, `DPSC_CMD_REF, 0, 3);
    ex(9'h1ed, 9'h028);
    odt <= 0;
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e2, 9'h100);
    repeat (15) @(posedge ref_clk);
    ex(9'h002, 9'h002);
    m.drv(0, `DPSC_CMD_READ, 0, 3);
    ex(9'h1e1, 9'h101);
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    op_busy <= 1;
    m.drv(0, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e0, 9'h100);
    op_busy <= 0;
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    m.drv(0, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e8, 9'h080);
    m.drv(1, `DPSC_CMD_READ, 0, 2);
    ex(9'h1e0, 9'h080);
    m.drv(1, `DPSC_CMD_NOP, 0, 3);
    ex(9'h1e0, 9'h100);
    report_and_stop;
  end
endmodule // dpsc_power_ctl_test
`default_nettype wire
